// ---- elt_pkg.sv ----
// Constants shared by the excitation-loss trip logic
package elt_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int unsigned ELT_CLK_HZ          = 125000000;
    localparam int unsigned ELT_TICK_US         = 1000;
    localparam int unsigned ELT_TICK_CYCLES     = ELT_CLK_HZ / 1000000 * ELT_TICK_US;
    localparam int unsigned ELT_FIXED_DELAY_MS  = 1500;   // 1.5 s fixed path delay

    // ------------------------------------------------------------
    // Measurement scaling and fixed thresholds
    // ------------------------------------------------------------
    localparam int unsigned ELT_VOLT_LSB_MV     = 10;
    localparam int unsigned ELT_CURR_LSB_MA     = 1;
    localparam int unsigned ELT_DEAD_VOLT_MV    = 8000;   // 8 V
    localparam int unsigned ELT_NEG_VOLT_MV     = 10000;  // 10 V
    localparam int unsigned ELT_LIVE_CURR_MA    = 250;    // 0.25 A
    localparam logic [15:0] ELT_DEAD_VOLT   = 16'(ELT_DEAD_VOLT_MV / ELT_VOLT_LSB_MV);
    localparam logic [15:0] ELT_NEG_VOLT    = 16'(ELT_NEG_VOLT_MV / ELT_VOLT_LSB_MV);
    localparam logic [15:0] ELT_LIVE_CURR   = 16'(ELT_LIVE_CURR_MA / ELT_CURR_LSB_MA);
    localparam logic [7:0]  ELT_SEQ_NUM         = 8'h04;  // 0.8 = 4/5
    localparam logic [7:0]  ELT_SEQ_DEN         = 8'h05;
    localparam logic [7:0]  ELT_OC_NUM          = 8'h15;  // 1.05 = 21/20
    localparam logic [7:0]  ELT_OC_DEN          = 8'h14;
    localparam int unsigned ELT_SLOPE_FRAC      = 8;      // Slope is Q8.8

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ELT_ADR_CTRL         = 8'h00;
    localparam logic [7:0] ELT_ADR_STATUS       = 8'h04;
    localparam logic [7:0] ELT_ADR_IRQ_STAT     = 8'h08;
    localparam logic [7:0] ELT_ADR_IRQ_MASK     = 8'h0c;
    localparam logic [7:0] ELT_ADR_SET_BASE     = 8'h10;
    localparam int unsigned ELT_NUM_SET         = 11;

    // Setting slots, in address order from the setting base
    localparam int unsigned ELT_SET_ROTOR_THR   = 0;
    localparam int unsigned ELT_SET_SLOPE       = 1;
    localparam int unsigned ELT_SET_SALIENT_PT  = 2;
    localparam int unsigned ELT_SET_HV_THR      = 3;
    localparam int unsigned ELT_SET_CENTER      = 4;
    localparam int unsigned ELT_SET_RADIUS      = 5;
    localparam int unsigned ELT_SET_START_CURR  = 6;
    localparam int unsigned ELT_SET_RATED_CURR  = 7;
    localparam int unsigned ELT_SET_T1          = 8;
    localparam int unsigned ELT_SET_T2          = 9;
    localparam int unsigned ELT_SET_T3          = 10;

    // Control bits
    localparam int unsigned ELT_CTRL_ENABLE     = 0;
    localparam int unsigned ELT_CTRL_ARR2       = 1;
    localparam int unsigned ELT_CTRL_HYDRO      = 2;
    localparam int unsigned ELT_CTRL_ROTOR_OFF  = 3;
    localparam logic [3:0]  ELT_CTRL_RESET      = 4'h0;
    localparam logic [15:0] ELT_SET_RESET       = 16'h0000;

    // Interrupt event count
    localparam int unsigned ELT_NUM_EV          = 6;

endpackage : elt_pkg

// ---- elt_delay_timer.sv ----
// Millisecond delay timer that restarts whenever its condition drops
`timescale 1ns/1ns
module elt_delay_timer (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_tick,
    input  wire logic        i_cond,
    input  wire logic [15:0] i_delay,
    output logic             o_expired
);

    logic [15:0] count;

    // Count ticks while the condition holds, clear when it drops
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !i_cond) begin
            count <= 16'h0000;
        end else if (i_tick && count != 16'hffff) begin
            count <= count + 16'h0001;
        end
    end

    // Expired only while the condition has held the full delay
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_expired <= 1'b0;
        end else begin
            o_expired <= i_cond && (count >= i_delay);
        end
    end

endmodule : elt_delay_timer

// ---- elt_trip_logic.sv ----
// Excitation-loss decision logic with Wishbone setting registers
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ns

// Functional notes
// - Rotor undervoltage: fixed threshold or sloped power line
// - Rotor undervoltage gives excitation loss and switchover
// - Rotor and HV undervoltage together trip generator
// - Destabilization from rotor AND impedance boundary
// - Rotor criterion failed: impedance boundary alone destabilizes
// - Stator above 1.05 rated: reduce output
// - Asynchronous operation trips only after set delay
// - Overcurrent persisting past second delay trips
// - Hydraulic unit trips after short first delay
// - Fixed 1.5 s internal delay, not settable
// - Two logic arrangements selected by configuration
// - Terminal three-phase break: dead voltages, live current
// - Terminal one/two-phase break from sequence quantities
// - System-side break from voltages only
// - Any break reported and indicator lit
// - Circle center entered positive, placed at negative X
module elt_trip_logic #(
    parameter int unsigned P_TICK_CYCLES    = elt_pkg::ELT_TICK_CYCLES,
    parameter int unsigned P_FIXED_DELAY_MS = elt_pkg::ELT_FIXED_DELAY_MS
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // Measured quantities
    input  wire logic [15:0] i_rotor_voltage,
    input  wire logic [15:0] i_active_power,
    input  wire logic [15:0] i_imp_resistance,
    input  wire logic [15:0] i_imp_reactance,
    input  wire logic [15:0] i_hv_voltage,
    input  wire logic [15:0] i_stator_current,
    input  wire logic        i_rotor_circuit_open,
    input  wire logic [15:0] i_phase_a_voltage,
    input  wire logic [15:0] i_phase_b_voltage,
    input  wire logic [15:0] i_phase_c_voltage,
    input  wire logic [15:0] i_phase_a_current,
    input  wire logic [15:0] i_phase_b_current,
    input  wire logic [15:0] i_phase_c_current,
    input  wire logic [15:0] i_pos_seq_voltage,
    input  wire logic [15:0] i_neg_seq_voltage,
    input  wire logic [15:0] i_pos_seq_current,
    input  wire logic [15:0] i_neg_seq_current,
    input  wire logic [15:0] i_sys_a_voltage,
    input  wire logic [15:0] i_sys_b_voltage,
    input  wire logic [15:0] i_sys_c_voltage,
    input  wire logic [15:0] i_sys_pos_voltage,
    input  wire logic [15:0] i_sys_neg_voltage,
    // Commands and signals
    output logic             o_exc_loss,
    output logic             o_exc_switchover,
    output logic             o_destab,
    output logic             o_reduce_output,
    output logic             o_trip,
    output logic             o_term_vt_break,
    output logic             o_sys_vt_break,
    output logic             o_irq
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // True when a exceeds b scaled by num/den
    function automatic logic ratio_gt(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic [7:0]  num,
        input logic [7:0]  den
    );
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = a * den;
        rhs = b * num;
        return lhs > rhs;
    endfunction : ratio_gt

    // Square of a signed 17-bit value
    function automatic logic [33:0] sq17(input logic signed [16:0] v);
        logic signed [33:0] p;
        p = v * v;
        return 34'(p);
    endfunction : sq17

    // Merge write data into a 16-bit setting by byte lane
    function automatic logic [15:0] lane16(
        input logic [15:0] old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction : lane16

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [3:0]                     ctrl;
    logic [15:0]                    setting [elt_pkg::ELT_NUM_SET];
    logic [elt_pkg::ELT_NUM_EV-1:0] irq_stat;
    logic [elt_pkg::ELT_NUM_EV-1:0] irq_mask;
    logic [elt_pkg::ELT_NUM_EV-1:0] events;
    logic [elt_pkg::ELT_NUM_EV-1:0] w1c;
    logic [8:0]                     status;
    logic [5:0]                     word;
    logic [5:0]                     set_idx;
    logic                           is_set;
    logic                           wr_now;
    logic [31:0]                    next_rdata;

    assign word    = i_wb_adr[7:2];
    assign set_idx = word - elt_pkg::ELT_ADR_SET_BASE[7:2];
    assign is_set  = (word >= elt_pkg::ELT_ADR_SET_BASE[7:2])
                  && (set_idx < 6'(elt_pkg::ELT_NUM_SET));
    assign wr_now  = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
    assign w1c     = (wr_now && i_wb_adr == elt_pkg::ELT_ADR_IRQ_STAT && i_wb_sel[0])
                   ? i_wb_dat[elt_pkg::ELT_NUM_EV-1:0] : '0;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------

    // One ack per request, dropped the cycle after
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
        end
    end

    // Read mux, unmapped words read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_set) begin
            next_rdata = {16'h0000, setting[set_idx[3:0]]};
        end else begin
            case (i_wb_adr)
                elt_pkg::ELT_ADR_CTRL:     next_rdata = {28'h0, ctrl};
                elt_pkg::ELT_ADR_STATUS:   next_rdata = {23'h0, status};
                elt_pkg::ELT_ADR_IRQ_STAT: next_rdata = {26'h0, irq_stat};
                elt_pkg::ELT_ADR_IRQ_MASK: next_rdata = {26'h0, irq_mask};
                default:                   next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured with the ack
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
            o_wb_dat <= next_rdata;
        end
    end

    // Control and mask writes at the acknowledging edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl     <= elt_pkg::ELT_CTRL_RESET;
            irq_mask <= '0;
        end else if (wr_now && i_wb_sel[0]) begin
            if (i_wb_adr == elt_pkg::ELT_ADR_CTRL) begin
                ctrl <= i_wb_dat[3:0];
            end
            if (i_wb_adr == elt_pkg::ELT_ADR_IRQ_MASK) begin
                irq_mask <= i_wb_dat[elt_pkg::ELT_NUM_EV-1:0];
            end
        end
    end

    // Setting store
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int k = 0; k < elt_pkg::ELT_NUM_SET; k++) begin
                setting[k] <= elt_pkg::ELT_SET_RESET;
            end
        end else if (wr_now && is_set) begin
            setting[set_idx[3:0]] <= lane16(setting[set_idx[3:0]], i_wb_dat, i_wb_sel);
        end
    end

    // ------------------------------------------------------------
    // Criteria
    // ------------------------------------------------------------
    logic               en;
    logic signed [16:0] pwr_diff;
    logic signed [33:0] slope_line;
    logic signed [33:0] rotor_ext;
    logic signed [16:0] x_shift;
    logic [34:0]        dist2;
    logic [33:0]        rad2;
    logic               dead_term;
    logic               dead_sys;
    logic               term_break;
    logic               sys_break;
    logic               rotor_lv;
    logic               hv_lv;
    logic               imp_in;
    logic               destab_c;
    logic               overcur;

    assign en        = ctrl[elt_pkg::ELT_CTRL_ENABLE];
    assign pwr_diff  = $signed({i_active_power[15], i_active_power})
                     - $signed({setting[elt_pkg::ELT_SET_SALIENT_PT][15],
                                setting[elt_pkg::ELT_SET_SALIENT_PT]});
    assign slope_line = pwr_diff * $signed({1'b0, setting[elt_pkg::ELT_SET_SLOPE]});
    assign rotor_ext = $signed({10'h000, i_rotor_voltage, 8'h00});
    // Center stored positive, applied at -X
    assign x_shift   = $signed({i_imp_reactance[15], i_imp_reactance})
                     + $signed({1'b0, setting[elt_pkg::ELT_SET_CENTER]});
    assign dist2     = {1'b0, sq17($signed({i_imp_resistance[15], i_imp_resistance}))}
                     + {1'b0, sq17(x_shift)};
    assign rad2      = sq17($signed({1'b0, setting[elt_pkg::ELT_SET_RADIUS]}));

    assign dead_term = (i_phase_a_voltage < elt_pkg::ELT_DEAD_VOLT)
                    && (i_phase_b_voltage < elt_pkg::ELT_DEAD_VOLT)
                    && (i_phase_c_voltage < elt_pkg::ELT_DEAD_VOLT);
    assign dead_sys  = (i_sys_a_voltage < elt_pkg::ELT_DEAD_VOLT)
                    && (i_sys_b_voltage < elt_pkg::ELT_DEAD_VOLT)
                    && (i_sys_c_voltage < elt_pkg::ELT_DEAD_VOLT);

    // Terminal transformer break, three-phase or partial
    assign term_break = (dead_term
                      && ((i_phase_a_current > elt_pkg::ELT_LIVE_CURR)
                       || (i_phase_b_current > elt_pkg::ELT_LIVE_CURR)
                       || (i_phase_c_current > elt_pkg::ELT_LIVE_CURR)))
                     || ((i_neg_seq_voltage > elt_pkg::ELT_NEG_VOLT)
                      && ratio_gt(i_pos_seq_voltage, i_neg_seq_voltage,
                                  elt_pkg::ELT_SEQ_NUM, elt_pkg::ELT_SEQ_DEN)
                      && (i_neg_seq_current < elt_pkg::ELT_LIVE_CURR)
                      && (i_pos_seq_current > elt_pkg::ELT_LIVE_CURR));

    // System-side break, no current condition
    assign sys_break = dead_sys
                    || ((i_sys_neg_voltage > elt_pkg::ELT_NEG_VOLT)
                     && ratio_gt(i_sys_pos_voltage, i_sys_neg_voltage,
                                 elt_pkg::ELT_SEQ_NUM, elt_pkg::ELT_SEQ_DEN));

    // Registered criteria; a system-side break blocks HV undervoltage, a terminal break blocks the impedance criterion
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rotor_lv <= 1'b0;
            hv_lv    <= 1'b0;
            imp_in   <= 1'b0;
        end else begin
            rotor_lv <= en && !ctrl[elt_pkg::ELT_CTRL_ROTOR_OFF]
                     && ((i_rotor_voltage < setting[elt_pkg::ELT_SET_ROTOR_THR])
                      || (rotor_ext < slope_line));
            hv_lv    <= en && !sys_break
                     && (i_hv_voltage < setting[elt_pkg::ELT_SET_HV_THR]);
            imp_in   <= en && !term_break && (dist2 < {1'b0, rad2})
                     && (i_stator_current > setting[elt_pkg::ELT_SET_START_CURR]);
        end
    end

    // Rotor criterion out of service: boundary alone decides
    assign destab_c = imp_in && (rotor_lv || i_rotor_circuit_open
                               || ctrl[elt_pkg::ELT_CTRL_ROTOR_OFF]);
    assign overcur  = ctrl[elt_pkg::ELT_CTRL_ARR2] && (rotor_lv || destab_c)
                   && ratio_gt(i_stator_current,
                               setting[elt_pkg::ELT_SET_RATED_CURR],
                               elt_pkg::ELT_OC_NUM, elt_pkg::ELT_OC_DEN);

    // ------------------------------------------------------------
    // Time base and delay stages
    // ------------------------------------------------------------
    logic [16:0] tick_cnt;
    logic        tick;
    logic        exc_dly;
    logic        hv_dly;
    logic        t1_dly;
    logic        t2_dly;
    logic        t3_dly;
    logic        t1_sel;

    // Millisecond tick
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            tick_cnt <= 17'h00000;
            tick     <= 1'b0;
        end else begin
            tick     <= tick_cnt == 17'(P_TICK_CYCLES - 1);
            tick_cnt <= (tick_cnt == 17'(P_TICK_CYCLES - 1))
                      ? 17'h00000 : tick_cnt + 17'h00001;
        end
    end

    // Short first stage: arrangement one or hydro
    assign t1_sel = !ctrl[elt_pkg::ELT_CTRL_ARR2] || ctrl[elt_pkg::ELT_CTRL_HYDRO];

    elt_delay_timer u_exc_tn (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick),
        .i_cond    (rotor_lv),
        .i_delay   (16'(P_FIXED_DELAY_MS)),
        .o_expired (exc_dly)
    );

    elt_delay_timer u_hv_tn (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick),
        .i_cond    (rotor_lv && hv_lv),
        .i_delay   (16'(P_FIXED_DELAY_MS)),
        .o_expired (hv_dly)
    );

    elt_delay_timer u_t1 (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick),
        .i_cond    (destab_c && t1_sel),
        .i_delay   (setting[elt_pkg::ELT_SET_T1]),
        .o_expired (t1_dly)
    );

    elt_delay_timer u_t2 (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick),
        .i_cond    (overcur),
        .i_delay   (setting[elt_pkg::ELT_SET_T2]),
        .o_expired (t2_dly)
    );

    elt_delay_timer u_t3 (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_tick    (tick),
        .i_cond    (destab_c && !t1_sel),
        .i_delay   (setting[elt_pkg::ELT_SET_T3]),
        .o_expired (t3_dly)
    );

    // ------------------------------------------------------------
    // Output commands
    // ------------------------------------------------------------

    // Commands and indicators, all registered
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_exc_loss       <= 1'b0;
            o_exc_switchover <= 1'b0;
            o_destab         <= 1'b0;
            o_reduce_output  <= 1'b0;
            o_trip           <= 1'b0;
            o_term_vt_break  <= 1'b0;
            o_sys_vt_break   <= 1'b0;
        end else begin
            o_exc_loss       <= exc_dly;
            o_exc_switchover <= exc_dly;
            o_destab         <= destab_c;
            o_reduce_output  <= overcur;
            o_trip           <= hv_dly || t1_dly || t2_dly || t3_dly;
            o_term_vt_break  <= en && term_break;
            o_sys_vt_break   <= en && sys_break;
        end
    end

    // ------------------------------------------------------------
    // Status and interrupts
    // ------------------------------------------------------------
    logic [elt_pkg::ELT_NUM_EV-1:0] ev_level;
    logic [elt_pkg::ELT_NUM_EV-1:0] ev_prev;

    assign status   = {o_sys_vt_break, o_term_vt_break, o_trip, o_exc_loss,
                       overcur, o_destab, imp_in, hv_lv, rotor_lv};
    assign ev_level = {o_sys_vt_break, o_term_vt_break, o_trip,
                       o_reduce_output, o_destab, o_exc_loss};
    assign events   = ev_level & ~ev_prev;

    // Rising-edge detect of each event source
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ev_prev <= '0;
        end else begin
            ev_prev <= ev_level;
        end
    end

    // Sticky status, a new event wins over a clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~w1c) | events;
        end
    end

    // Level interrupt from unmasked sticky bits
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat & irq_mask);
        end
    end

endmodule : elt_trip_logic

// ---- elt_sva.sv ----
// Port assertions for the excitation-loss trip logic
`timescale 1ns/1ns
module elt_sva (
    input wire logic        i_clk_sys, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic [15:0] i_phase_a_voltage, i_phase_b_voltage, i_phase_c_voltage,
    input wire logic [15:0] i_phase_a_current, i_phase_b_current, i_phase_c_current,
    input wire logic [15:0] i_pos_seq_voltage, i_neg_seq_voltage, i_pos_seq_current,
    input wire logic [15:0] i_neg_seq_current, i_sys_a_voltage, i_sys_b_voltage,
    input wire logic [15:0] i_sys_c_voltage, i_sys_pos_voltage, i_sys_neg_voltage,
    input wire logic        o_exc_loss, o_exc_switchover, o_term_vt_break, o_sys_vt_break
);
    // ----
    // Break conditions
    // ----
    logic term_brk;
    logic sys_brk;
    assign term_brk = (i_phase_a_voltage < 16'h0320 && i_phase_b_voltage < 16'h0320
        && i_phase_c_voltage < 16'h0320 && (i_phase_a_current > 16'h00fa
        || i_phase_b_current > 16'h00fa || i_phase_c_current > 16'h00fa))
        || (i_neg_seq_voltage > 16'h03e8 && {4'h0, i_pos_seq_voltage} * 20'h5
        > {4'h0, i_neg_seq_voltage} * 20'h4 && i_neg_seq_current < 16'h00fa
        && i_pos_seq_current > 16'h00fa);
    assign sys_brk = (i_sys_a_voltage < 16'h0320 && i_sys_b_voltage < 16'h0320
        && i_sys_c_voltage < 16'h0320) || (i_sys_neg_voltage > 16'h03e8
        && {4'h0, i_sys_pos_voltage} * 20'h5 > {4'h0, i_sys_neg_voltage} * 20'h4);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    // ----
    // Assertions
    // ----
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack too long");
    chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no ack");
    chk_unmapped_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr >= 8'h3c
        |-> o_wb_dat == 32'h0) else $error("unmapped nonzero");
    chk_status_upper: assert property (o_wb_ack && !i_wb_we && i_wb_adr[7:2] == 6'h01
        |-> o_wb_dat[31:9] == 23'h0) else $error("status upper bits set");
    chk_switch_pair: assert property (o_exc_loss == o_exc_switchover)
        else $error("switchover differs");
    chk_loss_delay: assert property ($rose(o_exc_loss) |-> !$past(o_exc_loss, 8))
        else $error("loss too soon");
    chk_term_cause: assert property (o_term_vt_break |-> $past(term_brk))
        else $error("term break uncaused");
    chk_sys_cause: assert property (o_sys_vt_break |-> $past(sys_brk))
        else $error("sys break uncaused");
endmodule : elt_sva

// ---- elt_front_model.sv ----
// Measurement front end model feeding computed quantities
`timescale 1ns/1ns
module elt_front_model (
    input  wire logic              i_clk_sys,
    input  wire logic [20:0][15:0] i_vals,
    output logic      [20:0][15:0] o_meas
);
    // One sample of latency
    always_ff @(posedge i_clk_sys) begin
        o_meas <= i_vals;
    end
endmodule : elt_front_model

// ---- tb.sv ----
// Self-checking bench for the excitation-loss trip logic
`timescale 1ns/1ns
module tb;
    logic        i_clk_sys, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_rotor_circuit_open;
    logic [7:0]  i_wb_adr;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, rd;
    logic        o_wb_ack, o_exc_loss, o_exc_switchover, o_destab, o_reduce_output, o_trip;
    logic        o_term_vt_break, o_sys_vt_break, o_irq, t, s;
    logic [15:0] i_rotor_voltage, i_active_power, i_imp_resistance, i_imp_reactance;
    logic [15:0] i_hv_voltage, i_stator_current, i_phase_a_voltage, i_phase_b_voltage;
    logic [15:0] i_phase_c_voltage, i_phase_a_current, i_phase_b_current, i_phase_c_current;
    logic [15:0] i_pos_seq_voltage, i_neg_seq_voltage, i_pos_seq_current, i_neg_seq_current;
    logic [15:0] i_sys_a_voltage, i_sys_b_voltage, i_sys_c_voltage, i_sys_pos_voltage;
    logic [15:0] i_sys_neg_voltage;
    logic [20:0][15:0] vals, meas;
    int          bad_count, checked, n, m[21];
    assign {i_sys_neg_voltage, i_sys_pos_voltage, i_sys_c_voltage, i_sys_b_voltage,
        i_sys_a_voltage, i_neg_seq_current, i_pos_seq_current, i_neg_seq_voltage,
        i_pos_seq_voltage, i_phase_c_current, i_phase_b_current, i_phase_a_current,
        i_phase_c_voltage, i_phase_b_voltage, i_phase_a_voltage, i_stator_current,
        i_hv_voltage, i_imp_reactance, i_imp_resistance, i_active_power,
        i_rotor_voltage} = meas;
    elt_trip_logic #(.P_TICK_CYCLES(4), .P_FIXED_DELAY_MS(3)) i_dut (.*);
    elt_front_model i_front (.i_clk_sys(i_clk_sys), .i_vals(vals), .o_meas(meas));
    // Clock and watchdog
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        bad_count++;
        end_of_test();
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge i_clk_sys);
        {i_wb_cyc, i_wb_stb} <= 2'h3;
        i_wb_we <= we;
        i_wb_adr <= a;
        i_wb_dat <= d;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        rd = o_wb_dat;
        {i_wb_cyc, i_wb_stb} <= 2'h0;
    endtask : wb
    task automatic apply();
        @(posedge i_clk_sys);
        foreach (m[i]) vals[i] <= 16'(m[i]);
    endtask : apply
    task automatic wait_edges(input int k);
        repeat (k) @(posedge i_clk_sys);
    endtask : wait_edges
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        {i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_rotor_circuit_open} = 5'h00;
        {i_wb_adr, i_wb_dat, vals} = '0;
        i_wb_sel = 4'hf;
        void'($urandom(69));
        wait_edges(8);
        i_rst_n <= 1'b1;
        for (int a = 0; a < 64; a += 4) begin
            wb(1'b0, 8'(a), 32'h0);
            chk("reset read", rd, 32'h0);
        end
        wb(1'b1, 8'h10, 32'h1234_01f4);
        wb(1'b0, 8'h10, 32'h0);
        chk("setting width", rd, 32'h0000_01f4);
        wb(1'b1, 8'h00, 32'h1);
        for (int k = 0; k < 60; k++) begin
            foreach (m[i]) m[i] = (i inside {[9:11], 14, 15}) ? $urandom_range(500)
                : 150 + $urandom_range(1000);
            apply();
            wait_edges(5);
            t = (m[6] < 800 && m[7] < 800 && m[8] < 800 && (m[9] > 250 || m[10] > 250
                || m[11] > 250)) || (m[13] > 1000 && m[12] * 5 > m[13] * 4
                && m[15] < 250 && m[14] > 250);
            s = (m[16] < 800 && m[17] < 800 && m[18] < 800)
                || (m[20] > 1000 && m[19] * 5 > m[20] * 4);
            chk("terminal break", o_term_vt_break, t);
            chk("system break", o_sys_vt_break, s);
            wb(1'b0, 8'h04, 32'h0);
            chk("status", {o_destab, o_reduce_output, rd[8:7], rd[0]},
                {2'h0, s, t, m[0] < 500});
        end
        foreach (m[i]) m[i] = 1000;
        m[0] = 400;
        apply();
        wb(1'b1, 8'h08, 32'h3f);
        wb(1'b1, 8'h0c, 32'h1);
        m[0] = 1000;
        apply();
        wait_edges(30);
        chk("short dip", o_exc_loss, 1'b0);
        wb(1'b1, 8'h1c, 32'h7d0);
        m[0] = 400;
        apply();
        n = 0;
        while (o_exc_loss !== 1'b1 && n < 60) begin
            @(posedge i_clk_sys);
            n++;
        end
        chk("fixed delay", n >= 12 && n <= 24, 1'b1);
        chk("switchover", o_exc_switchover, 1'b1);
        chk("trip", o_trip, 1'b1);
        wait_edges(3);
        chk("irq raised", o_irq, 1'b1);
        wb(1'b1, 8'h0c, 32'h0);
        wait_edges(2);
        chk("irq masked", o_irq, 1'b0);
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b1, 8'h0c, 32'h1);
        wait_edges(2);
        chk("irq cleared", o_irq, 1'b0);
        end_of_test();
    end
endmodule : tb
bind elt_trip_logic elt_sva i_sva (.*);
